// ===== opfl_cfg_regs.sv
// Output pin and FIFO level configuration registers with serial port
`timescale 1ns/10ps
`default_nettype none
module opfl_cfg_regs
  import opfl_pkg::*;
#(
  parameter int         FIFO_CNT_W   = 7,
  parameter logic [7:0] CHIP_STATUS  = 8'h00,
  parameter logic [7:0] TEST_ONE_RST = 8'h00,
  parameter logic [7:0] TEST_TWO_RST = 8'h00
)(
  input  wire logic                  core_clk,
  input  wire logic                  rst,
  input  wire logic                  clk_en,
  input  wire opfl_spi_in_t          spi_in,
  output logic                       spi_miso,
  output logic                       spi_miso_oe,
  input  wire logic                  sleep_mode,
  input  wire logic [FIFO_CNT_W-1:0] rx_fifo_count,
  input  wire logic [FIFO_CNT_W-1:0] tx_fifo_count,
  output opfl_pin_cfg_t              output_pin_two_cfg,
  output opfl_pin_cfg_t              output_pin_one_cfg,
  output opfl_pin_cfg_t              output_pin_zero_cfg,
  output logic                       pin_drive_strength,
  output logic                       pin_zero_spare,
  output logic                       fifo_spare,
  output logic                       wake_retention_bit,
  output logic [1:0]                 rx_atten_code,
  output logic [3:0]                 fifo_level_code,
  output logic [7:0]                 test_word_one,
  output logic [7:0]                 test_word_two,
  output logic                       rx_thr_hit,
  output logic                       tx_thr_hit
);

  // Counts must reach 64 bytes
  if (FIFO_CNT_W < 7)
  begin : g_cnt_chk
    $error("FIFO_CNT_W too narrow for 64 bytes");
  end

  // Pin synchronisers: bit 0 sclk, 1 cs_n, 2 mosi
  localparam logic [2:0] PIN_IDLE = 3'h2;
  logic [2:0] sy1_r, sy2_r, sy3_r, flt_r, flt_d_r;
  logic [2:0] flt_nxt;

  genvar gi;
  generate
    for (gi = 0; gi < 3; gi++)
    begin : g_flt
      // Glitch filter: only take a level that two stages agree on
      assign flt_nxt[gi] = (sy2_r[gi] == sy3_r[gi]) ? sy3_r[gi] : flt_r[gi];
    end
  endgenerate

  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      sy1_r   <= PIN_IDLE;
      sy2_r   <= PIN_IDLE;
      sy3_r   <= PIN_IDLE;
      flt_r   <= PIN_IDLE;
      flt_d_r <= PIN_IDLE;
    end
    else if (clk_en)
    begin
      sy1_r   <= spi_in;
      sy2_r   <= sy1_r;
      sy3_r   <= sy2_r;
      flt_r   <= flt_nxt;
      flt_d_r <= flt_r;
    end
  end

  wire cs_act    = ~flt_r[1];
  wire cs_fall   = flt_d_r[1] & ~flt_r[1];
  wire sclk_rise = cs_act & flt_r[0] & ~flt_d_r[0];
  wire sclk_fall = cs_act & ~flt_r[0] & flt_d_r[0];

  // Serial transfer state
  logic [2:0] bit_cnt_r;
  logic [6:0] shift_r;
  logic       hdr_seen_r, rd_r, burst_r, stop_r;
  logic [5:0] addr_r;
  logic [7:0] tx_sh_r;
  logic       miso_r, miso_oe_r;

  // Configuration registers
  opfl_pin_cfg_t pin_two_r;
  logic [7:0]    pin_one_r, pin_zero_r, fifo_lvl_r;
  logic [7:0]    tw_one_r, tw_two_r;
  logic          sleep_d_r, rx_hit_r, tx_hit_r;

  function automatic logic [7:0] rd_val(input logic [5:0] a);
    unique case (a)
      OPFL_ADDR_PIN_TWO:  rd_val = {1'b0, pin_two_r};
      OPFL_ADDR_PIN_ONE:  rd_val = pin_one_r;
      OPFL_ADDR_PIN_ZERO: rd_val = pin_zero_r;
      OPFL_ADDR_FIFO_LVL: rd_val = fifo_lvl_r;
      OPFL_ADDR_TEST_ONE: rd_val = TEST_ONE_RST;
      OPFL_ADDR_TEST_TWO: rd_val = TEST_TWO_RST;
      default:            rd_val = 8'h00;
    endcase
  endfunction

  wire [7:0] rx_byte   = {shift_r, flt_r[2]};
  wire       byte_done = sclk_rise & (bit_cnt_r == 3'h7);
  wire       hdr_take  = byte_done & ~hdr_seen_r;
  wire       data_take = byte_done & hdr_seen_r & ~stop_r;
  wire [5:0] addr_inc  = addr_r + 6'h01;
  // Writes refused while asleep so the held settings cannot move
  wire       wr_ok     = data_take & ~rd_r & ~sleep_mode;
  wire       wr_two    = wr_ok & (addr_r == OPFL_ADDR_PIN_TWO);
  wire       wr_one    = wr_ok & (addr_r == OPFL_ADDR_PIN_ONE);
  wire       wr_zero   = wr_ok & (addr_r == OPFL_ADDR_PIN_ZERO);
  wire       wr_fifo   = wr_ok & (addr_r == OPFL_ADDR_FIFO_LVL);
  wire       hdr_rd    = rx_byte[OPFL_HDR_READ_BIT];
  wire       hdr_burst = rx_byte[OPFL_HDR_BURST_BIT];
  wire [7:0] tx_nxt    = hdr_take ? (hdr_rd ? rd_val(rx_byte[5:0]) : CHIP_STATUS)
                       : ((rd_r & burst_r) ? rd_val(addr_inc) : CHIP_STATUS);
  wire       wake      = sleep_d_r & ~sleep_mode;

  // Threshold figures from the level code
  wire [3:0] lvl     = fifo_lvl_r[OPFL_LVL_LSB +: 4];
  wire [6:0] lvl_x4  = {1'b0, lvl, 2'b00};
  wire [6:0] rx_thr  = lvl_x4 + OPFL_THR_STEP;
  wire [6:0] tx_thr  = OPFL_TX_THR_BASE - lvl_x4;
  wire       rx_hit_nxt = rx_fifo_count >= FIFO_CNT_W'(rx_thr);
  wire       tx_hit_nxt = tx_fifo_count >= FIFO_CNT_W'(tx_thr);

  always_ff @(posedge core_clk)
  begin
    if (rst || (clk_en && !cs_act))
    begin
      bit_cnt_r  <= 3'h0;
      shift_r    <= 7'h00;
      hdr_seen_r <= 1'b0;
      rd_r       <= 1'b0;
      burst_r    <= 1'b0;
      stop_r     <= 1'b0;
      addr_r     <= 6'h00;
    end
    else if (clk_en && sclk_rise)
    begin
      bit_cnt_r <= bit_cnt_r + 3'h1;
      shift_r   <= rx_byte[6:0];
      if (hdr_take)
      begin
        hdr_seen_r <= 1'b1;
        rd_r       <= hdr_rd;
        burst_r    <= hdr_burst;
        addr_r     <= rx_byte[5:0];
      end
      else if (data_take)
      begin
        // Single access ends after one data byte; burst walks the address
        stop_r <= ~burst_r;
        addr_r <= addr_inc;
      end
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      tx_sh_r   <= 8'h00;
      miso_r    <= 1'b0;
      miso_oe_r <= 1'b0;
    end
    else if (clk_en)
    begin
      miso_oe_r <= cs_act;
      if (cs_fall)
      begin
        miso_r  <= CHIP_STATUS[7];
        tx_sh_r <= {CHIP_STATUS[6:0], 1'b0};
      end
      else if (byte_done)
        tx_sh_r <= tx_nxt;
      else if (sclk_fall)
      begin
        miso_r  <= tx_sh_r[7];
        tx_sh_r <= {tx_sh_r[6:0], 1'b0};
      end
    end
  end

  // No sleep reset path: contents ride through sleep untouched
  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      pin_two_r  <= OPFL_PIN_TWO_RST;
      pin_one_r  <= OPFL_PIN_ONE_RST;
      pin_zero_r <= OPFL_PIN_ZERO_RST;
      fifo_lvl_r <= OPFL_FIFO_LVL_RST;
    end
    else if (clk_en)
    begin
      if (wr_two)
        pin_two_r <= rx_byte[6:0];
      if (wr_one)
        pin_one_r <= rx_byte;
      if (wr_zero)
        pin_zero_r <= rx_byte;
      if (wr_fifo)
        fifo_lvl_r <= rx_byte;
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      sleep_d_r <= 1'b0;
      tw_one_r  <= TEST_ONE_RST;
      tw_two_r  <= TEST_TWO_RST;
      rx_hit_r  <= 1'b0;
      tx_hit_r  <= 1'b0;
    end
    else if (clk_en)
    begin
      sleep_d_r <= sleep_mode;
      rx_hit_r  <= rx_hit_nxt;
      tx_hit_r  <= tx_hit_nxt;
      if (wake)
      begin
        // Analog side only; register reads keep the reset figures
        tw_one_r <= fifo_lvl_r[OPFL_RET_BIT] ? OPFL_TW_ONE_RET1 : OPFL_TW_ONE_RET0;
        tw_two_r <= fifo_lvl_r[OPFL_RET_BIT] ? OPFL_TW_TWO_RET1 : OPFL_TW_TWO_RET0;
      end
    end
  end

  assign spi_miso            = miso_r;
  assign spi_miso_oe         = miso_oe_r;
  assign output_pin_two_cfg  = pin_two_r;
  assign output_pin_one_cfg  = opfl_pin_cfg_t'(pin_one_r[6:0]);
  assign output_pin_zero_cfg = opfl_pin_cfg_t'(pin_zero_r[6:0]);
  assign pin_drive_strength  = pin_one_r[OPFL_DS_BIT];
  assign pin_zero_spare      = pin_zero_r[7];
  assign fifo_spare          = fifo_lvl_r[7];
  assign wake_retention_bit  = fifo_lvl_r[OPFL_RET_BIT];
  assign rx_atten_code       = fifo_lvl_r[OPFL_ATTEN_LSB +: 2];
  assign fifo_level_code     = lvl;
  assign test_word_one       = tw_one_r;
  assign test_word_two       = tw_two_r;
  assign rx_thr_hit          = rx_hit_r;
  assign tx_thr_hit          = tx_hit_r;

  // Checks
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  AST_PIN_TWO_RST: assert property ($fell(rst) |-> pin_two_r == 7'h29)
    else $error("pin two reset code wrong");
  AST_PIN_ONE_RST: assert property ($fell(rst) |-> pin_one_r == 8'h2E)
    else $error("pin one reset code wrong");
  AST_PIN_ZERO_RST: assert property ($fell(rst) |-> pin_zero_r[5:0] == 6'h3F)
    else $error("pin zero reset code wrong");
  AST_POL_DS_RST: assert property ($fell(rst) |-> !pin_two_r.polarity && !pin_one_r[6]
    && !pin_zero_r[6] && !pin_drive_strength && rx_atten_code == 2'h0)
    else $error("polarity, drive or attenuation reset wrong");
  AST_SLEEP_HOLD: assert property (sleep_mode && $past(sleep_mode) |->
    $stable(pin_one_r) && $stable(pin_zero_r) && $stable(fifo_lvl_r) && $stable(pin_two_r))
    else $error("register changed while asleep");
  AST_WAKE_RET1: assert property (clk_en && wake && fifo_lvl_r[6] |=>
    tw_one_r == 8'h35 && tw_two_r == 8'h81)
    else $error("wake words wrong with retention set");
  AST_WAKE_RET0: assert property (clk_en && wake && !fifo_lvl_r[6] |=>
    tw_one_r == 8'h31 && tw_two_r == 8'h88)
    else $error("wake words wrong with retention clear");
  AST_TEST_READ: assert property (rd_val(OPFL_ADDR_TEST_ONE) == TEST_ONE_RST
    && rd_val(OPFL_ADDR_TEST_TWO) == TEST_TWO_RST)
    else $error("test word read not reset value");
  AST_RX_THR: assert property (clk_en && $past(clk_en) && !$past(rst) |->
    rx_thr_hit == ($past(rx_fifo_count) >= 4 * ($past(fifo_level_code) + 1)))
    else $error("rx threshold flag wrong");
  AST_TX_THR: assert property (clk_en && $past(clk_en) && !$past(rst) |->
    tx_thr_hit == ($past(tx_fifo_count) >= 61 - 4 * $past(fifo_level_code)))
    else $error("tx threshold flag wrong");
  AST_WRITE_ONE: assert property (clk_en && wr_one |=> pin_one_r == $past(rx_byte))
    else $error("write to pin one lost");
  AST_BIT7_ZERO: assert property (hdr_take && hdr_rd && rx_byte[5:0] == OPFL_ADDR_PIN_TWO
    |-> tx_nxt[7] == 1'b0)
    else $error("pin two bit 7 not zero");

  COV_WRITE: cover property (wr_fifo);
  COV_BURST_READ: cover property (data_take && rd_r && burst_r);
  COV_WAKE_RET: cover property (wake && fifo_lvl_r[6]);

endmodule
`default_nettype wire

// ===== opfl_host_model.sv
// Host side serial master model for the configuration port
`timescale 1ns/10ps
`default_nettype none
module opfl_host_model
  import opfl_pkg::*;
#(
  parameter int HALF = 8
)(
  input  wire logic   core_clk,
  output opfl_spi_in_t spi_in,
  input  wire logic   spi_miso
);
  initial spi_in = 3'b110;
  // Long phases give the pin filter room
  task automatic step();
    repeat (HALF) @(posedge core_clk);
    #1;
  endtask
  task automatic sel();
    spi_in.spi_cs_n = 1'b0;
    step();
  endtask
  // Released data line shows the inverse of its last bit
  task automatic desel();
    step();
    spi_in.spi_cs_n = 1'b1;
    spi_in.spi_mosi = ~spi_in.spi_mosi;
    step();
  endtask
  // Header then data, msb first, mode 0
  task automatic xbyte(input logic [7:0] tx, output logic [7:0] rx);
    for (int i = 7; i >= 0; i--)
    begin
      spi_in.spi_mosi = tx[i];
      step();
      spi_in.spi_sclk = 1'b1;
      rx[i] = spi_miso;
      step();
      spi_in.spi_sclk = 1'b0;
    end
  endtask
endmodule
`default_nettype wire

// ===== opfl_pkg.sv
// Package for the output pin and FIFO level configuration registers
package opfl_pkg;

  // Register offsets on the serial configuration port
  localparam logic [5:0] OPFL_ADDR_PIN_TWO   = 6'h00;
  localparam logic [5:0] OPFL_ADDR_PIN_ONE   = 6'h01;
  localparam logic [5:0] OPFL_ADDR_PIN_ZERO  = 6'h02;
  localparam logic [5:0] OPFL_ADDR_FIFO_LVL  = 6'h03;
  localparam logic [5:0] OPFL_ADDR_TEST_TWO  = 6'h2C;
  localparam logic [5:0] OPFL_ADDR_TEST_ONE  = 6'h2D;

  // Header byte: read flag, burst flag, address
  localparam int OPFL_HDR_READ_BIT  = 7;
  localparam int OPFL_HDR_BURST_BIT = 6;

  // Field positions
  localparam int OPFL_POL_BIT    = 6;
  localparam int OPFL_DS_BIT     = 7;
  localparam int OPFL_RET_BIT    = 6;
  localparam int OPFL_ATTEN_LSB  = 4;
  localparam int OPFL_LVL_LSB    = 0;

  // Reset values
  localparam logic [6:0] OPFL_PIN_TWO_RST  = 7'h29;
  localparam logic [7:0] OPFL_PIN_ONE_RST  = 8'h2E;
  localparam logic [7:0] OPFL_PIN_ZERO_RST = 8'h3F;
  localparam logic [7:0] OPFL_FIFO_LVL_RST = 8'h07;

  // Analog test words loaded on wake
  localparam logic [7:0] OPFL_TW_ONE_RET0 = 8'h31;
  localparam logic [7:0] OPFL_TW_TWO_RET0 = 8'h88;
  localparam logic [7:0] OPFL_TW_ONE_RET1 = 8'h35;
  localparam logic [7:0] OPFL_TW_TWO_RET1 = 8'h81;

  // Thresholds: rx = step*(n+1), tx = base - step*n
  localparam logic [6:0] OPFL_THR_STEP    = 7'h04;
  localparam logic [6:0] OPFL_TX_THR_BASE = 7'h3D;

  typedef struct packed {
    logic       polarity;
    logic [5:0] signal_sel;
  } opfl_pin_cfg_t;

  typedef struct packed {
    logic       spi_mosi;
    logic       spi_cs_n;
    logic       spi_sclk;
  } opfl_spi_in_t;

endpackage

// ===== test_opfl_cfg_regs.sv
// Self-checking bench for the configuration register block
`timescale 1ns/10ps
`default_nettype none
module test_opfl_cfg_regs;
  import opfl_pkg::*;
  localparam logic [7:0] T1 = 8'h5A; // Arbitrary
  localparam logic [7:0] T2 = 8'hC3; // Arbitrary
  logic          core_clk = 1'b0;
  logic          rst = 1'b1;
  logic          sleep_mode = 1'b0;
  logic          ce = 1'b1;
  logic [6:0]    rx_cnt = 7'h00;
  logic [6:0]    tx_cnt = 7'h00;
  opfl_spi_in_t  spi_in;
  logic          miso, oe, ds, zsp, fsp, ret, rxh, txh;
  logic [1:0]    att;
  logic [3:0]    lvl;
  logic [7:0]    tw1, tw2, rd;
  opfl_pin_cfg_t p2, p1, p0;
  int            fail_count = 0;
  int            check_count = 0;
  logic [23:0]   rows [5] = '{24'h00FF7F, 24'h01C5C5, 24'h024B4B, 24'h051200, {8'h2D, 8'h77, T1}};
  always #25 core_clk = ~core_clk;
  opfl_cfg_regs #(.TEST_ONE_RST(T1), .TEST_TWO_RST(T2)) dut (
    .core_clk(core_clk), .rst(rst), .clk_en(ce), .spi_in(spi_in), .spi_miso(miso),
    .spi_miso_oe(oe), .sleep_mode(sleep_mode), .rx_fifo_count(rx_cnt),
    .tx_fifo_count(tx_cnt), .output_pin_two_cfg(p2), .output_pin_one_cfg(p1),
    .output_pin_zero_cfg(p0), .pin_drive_strength(ds), .pin_zero_spare(zsp),
    .fifo_spare(fsp), .wake_retention_bit(ret), .rx_atten_code(att),
    .fifo_level_code(lvl), .test_word_one(tw1), .test_word_two(tw2),
    .rx_thr_hit(rxh), .tx_thr_hit(txh));
  opfl_host_model host (.core_clk(core_clk), .spi_in(spi_in), .spi_miso(miso));
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp)
    begin
      fail_count++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic acc(input logic [7:0] hdr, input logic [7:0] wd, output logic [7:0] rv);
    logic [7:0] st;
    host.sel();
    host.xbyte(hdr, st);
    host.xbyte(wd, rv);
    host.desel();
  endtask
  task automatic do_rst();
    @(posedge core_clk) #1 rst = 1'b1;
    repeat (5) @(posedge core_clk);
    #1 rst = 1'b0;
    repeat (6) @(posedge core_clk);
    chk({p2, p1, ds, p0, lvl, att, ret}, {7'h29, 7'h2E, 1'b0, 7'h3F, 4'h7, 3'b000});
    chk({tw1, tw2}, {T1, T2});
    $display("reset test done");
  endtask
  // Sleep with a given level byte, refused write, then wake
  task automatic nap(input logic [7:0] lv, input logic [15:0] tw);
    acc(8'h03, lv, rd);
    chk({fsp, ret}, lv[7:6]);
    @(posedge core_clk) #1 sleep_mode = 1'b1;
    acc(8'h00, 8'h00, rd);
    chk(p2, 7'h7F);
    @(posedge core_clk) #1 sleep_mode = 1'b0;
    repeat (3) @(posedge core_clk);
    chk({tw1, tw2}, tw);
    acc(8'hAD, 8'h00, rd);
    chk(rd, T1);
    $display("sleep test done");
  endtask
  initial
  begin
    do_rst();
    foreach (rows[i])
    begin
      acc(rows[i][23:16], rows[i][15:8], rd);
      acc(8'h80 | rows[i][23:16], 8'h00, rd);
      chk(rd, rows[i][7:0]);
    end
    chk({p2, p1, ds, p0}, {7'h7F, 7'h45, 1'b1, 7'h4B});
    $display("table test done");
    for (int n = 0; n < 16; n++)
    begin
      acc(8'h03, {2'b00, n[1:0], n[3:0]}, rd);
      chk({att, lvl}, {n[1:0], n[3:0]});
      for (int d = 0; d < 2; d++)
      begin
        @(posedge core_clk) #1;
        rx_cnt = 7'(4 * (n + 1) - 1 + d);
        tx_cnt = 7'(60 - 4 * n + d);
        repeat (3) @(posedge core_clk);
        chk({rxh, txh}, {d[0], d[0]});
      end
    end
    // Enable low freezes the hit flag
    @(posedge core_clk) #1 ce = 1'b0;
    rx_cnt = 7'h00;
    repeat (3) @(posedge core_clk);
    chk(rxh, 1'b1);
    #1 ce = 1'b1;
    repeat (3) @(posedge core_clk);
    chk(rxh, 1'b0);
    $display("threshold test done");
    host.sel();
    host.xbyte(8'h41, rd);
    host.xbyte(8'h11, rd);
    host.xbyte(8'hA2, rd);
    host.desel();
    chk({p1, ds, p0, zsp}, {7'h11, 1'b0, 7'h22, 1'b1});
    host.sel();
    host.xbyte(8'hC1, rd);
    host.xbyte(8'h00, rd);
    chk(rd, 8'h11);
    host.xbyte(8'h00, rd);
    chk({rd, oe}, {8'hA2, 1'b1});
    host.desel();
    chk(oe, 1'b0);
    // Clock output moved off pin zero; trailing byte must be dropped
    host.sel();
    host.xbyte(8'h02, rd);
    host.xbyte(8'h4B, rd);
    host.xbyte(8'h99, rd);
    host.desel();
    chk({p0, zsp}, {7'h4B, 1'b0});
    $display("burst test done");
    nap(8'hC7, 16'h3581);
    nap(8'h07, 16'h3188);
    do_rst();
    report_and_stop();
  end
  // Whole run needs about 10400 cycles
  initial
  begin
    repeat (60000) @(posedge core_clk);
    fail_count++;
    report_and_stop();
  end
endmodule
`default_nettype wire
